// file: hdl/timer_cfg.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define OFF_COUNT_LOW    4'h0
`define OFF_HIGH_BUF     4'h4
`define OFF_CONTROL      4'h8
`define OFF_IRQ_STATUS   4'hC
`define BIT_RUN          7
`define BIT_EIGHT        6
`define BIT_SRC          5
`define BIT_EDGE         4
`define BIT_BYPASS       3
`define BIT_FLAG         0
`define BIT_IRQ_EN       1
`define RST_CONTROL      8'hFF
`define RST_HIGH_BUF     8'h00
`define RST_COUNT        16'h0000
`define CORE_PER_ICYC    4
`define INHIBIT_ICYC     2'h2
`endif

// file: hdl/timer_pkg.sv
// Types shared by the timer/counter and its bench.
// Constants live in timer_cfg.svh.
package timer_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic       timer_run;
    logic       eight_bit_select;
    logic       count_source_select;
    logic       edge_polarity_select;
    logic       prescaler_bypass;
    logic [2:0] prescale_ratio;
  } timer_control_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage

// file: hdl/prescaled_timer_counter_8_16.sv
// Prescaled 8/16-bit timer/counter with Avalon-MM register slave.
// Assumes synchronous inputs except the count pin, which is synchronised here.
`timescale 1ns/100ps
`include "timer_cfg.svh"

module prescaled_timer_counter_8_16 #(
  parameter int ICYC_DIV = `CORE_PER_ICYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire timer_pkg::avs_req_t i_avs,
  output logic                   o_avs_waitrequest,
  output logic [31:0]            o_avs_readdata,
  input  wire logic              i_external_count_input,
  input  wire logic              i_sleep,
  output logic                   o_instruction_clock,
  output logic                   o_overflow_irq
);
  import timer_pkg::*;

  bus_state_t     bus_ff;
  timer_control_t ctrl_ff;
  logic [15:0]    count_ff;
  logic [7:0]     high_buf_ff;
  logic [7:0]     presc_ff;
  logic [1:0]     inhibit_ff;
  logic [7:0]     icyc_ff;
  logic [2:0]     pin_ff;
  logic           flag_ff;
  logic           irq_en_ff;
  logic [31:0]    rdata_ff;
  logic           icyc_tick;
  logic           pin_edge;
  logic           src_pulse;
  logic           presc_out;
  logic           inc;
  logic           wrap;
  logic           take;
  logic           low_wr;
  logic           low_rd;
  logic           wr_en;
  logic [7:0]     wbyte;
  logic [7:0]     ratio_mask;
  logic [7:0]     nxt_icyc;
  logic           iclk_ff;

  // Bus handshake: every access takes one wait cycle, answered on the second edge
  assign take              = (i_avs.read | i_avs.write) && bus_ff == BUS_ACK;
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) && bus_ff == BUS_IDLE;
  assign o_avs_readdata    = rdata_ff;
  assign wr_en             = take && i_avs.write && i_avs.byteenable[0];
  assign wbyte             = i_avs.writedata[7:0];
  assign low_wr            = wr_en && i_avs.address == `OFF_COUNT_LOW;
  assign low_rd            = take && i_avs.read && i_avs.address == `OFF_COUNT_LOW;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bus_ff <= BUS_IDLE;
    end else if (bus_ff == BUS_ACK) begin
      bus_ff <= BUS_IDLE;
    end else if (i_avs.read | i_avs.write) begin
      bus_ff <= BUS_ACK;
    end
  end

  // Read data is captured in the wait cycle so it stands at the answering edge
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_avs.read && bus_ff == BUS_IDLE) begin
      unique case (i_avs.address)
        `OFF_COUNT_LOW:  rdata_ff <= {24'h00_0000, count_ff[7:0]};
        `OFF_HIGH_BUF:   rdata_ff <= {24'h00_0000, high_buf_ff};
        `OFF_CONTROL:    rdata_ff <= {24'h00_0000, ctrl_ff};
        `OFF_IRQ_STATUS: rdata_ff <= {30'h0000_0000, irq_en_ff, flag_ff};
        default:         rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control: assignment and mode bits may change any time, no stop needed
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_ff <= `RST_CONTROL;
    end else if (wr_en && i_avs.address == `OFF_CONTROL) begin
      ctrl_ff <= wbyte;
    end
  end

  // High buffer: written by software, refreshed by a low byte read
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      high_buf_ff <= `RST_HIGH_BUF;
    end else if (wr_en && i_avs.address == `OFF_HIGH_BUF) begin
      high_buf_ff <= wbyte;
    end else if (low_rd) begin
      high_buf_ff <= count_ff[15:8];
    end
  end

  // Instruction cycle clock derived from the core clock
  assign icyc_tick           = icyc_ff == 8'(ICYC_DIV - 1);
  assign nxt_icyc            = icyc_tick ? 8'h00 : icyc_ff + 8'h01;
  assign o_instruction_clock = iclk_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      icyc_ff <= 8'h00;
    end else begin
      icyc_ff <= nxt_icyc;
    end
  end

  // Registered, so the pin carries no compare glitches
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      iclk_ff <= 1'b1;
    end else begin
      iclk_ff <= nxt_icyc < 8'(ICYC_DIV / 2);
    end
  end

  // Count pin: two synchroniser flops, edge found between flops two and three
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_ff <= 3'h0;
    end else begin
      pin_ff <= {pin_ff[1:0], i_external_count_input};
    end
  end

  assign pin_edge = ctrl_ff.edge_polarity_select ? (pin_ff[2] & ~pin_ff[1])
                                                 : (~pin_ff[2] & pin_ff[1]);
  assign src_pulse = ctrl_ff.count_source_select ? pin_edge : icyc_tick;

  // Prescaler output fires when the selected low bits are all ones
  for (genvar b = 0; b < 8; b++) begin : mask_bit
    assign ratio_mask[b] = 3'(b) <= ctrl_ff.prescale_ratio;
  end

  assign presc_out = src_pulse && ((presc_ff & ratio_mask) == ratio_mask);

  // Prescaler runs only while assigned; a low byte write clears it only while assigned
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      presc_ff <= 8'h00;
    end else if (low_wr && !ctrl_ff.prescaler_bypass) begin
      presc_ff <= 8'h00;
    end else if (src_pulse && !ctrl_ff.prescaler_bypass && ctrl_ff.timer_run && !i_sleep) begin
      presc_ff <= presc_ff + 8'h01;
    end
  end

  // Inhibit window after a low byte write, counted in instruction cycles
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      inhibit_ff <= 2'h0;
    end else if (low_wr) begin
      inhibit_ff <= `INHIBIT_ICYC;
    end else if (icyc_tick && inhibit_ff != 2'h0) begin
      inhibit_ff <= inhibit_ff - 2'h1;
    end
  end

  // Sleep gates the increment, so no overflow can arise while asleep
  assign inc = ctrl_ff.timer_run && !i_sleep && inhibit_ff == 2'h0 && !low_wr
               && (ctrl_ff.prescaler_bypass ? src_pulse : presc_out);
  assign wrap = inc && (ctrl_ff.eight_bit_select ? count_ff[7:0] == 8'hFF
                                                 : count_ff == 16'hFFFF);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      count_ff <= `RST_COUNT;
    end else if (low_wr) begin
      count_ff <= {high_buf_ff, wbyte};
    end else if (inc && ctrl_ff.eight_bit_select) begin
      count_ff[7:0] <= count_ff[7:0] + 8'h01;
    end else if (inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Overflow flag: a wrap in the clearing cycle still sets it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      flag_ff <= 1'b0;
    end else if (wrap) begin
      flag_ff <= 1'b1;
    end else if (wr_en && i_avs.address == `OFF_IRQ_STATUS) begin
      flag_ff <= wbyte[`BIT_FLAG];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_en_ff <= 1'b0;
    end else if (wr_en && i_avs.address == `OFF_IRQ_STATUS) begin
      irq_en_ff <= wbyte[`BIT_IRQ_EN];
    end
  end

  assign o_overflow_irq = flag_ff && irq_en_ff;

  run_stop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ctrl_ff.timer_run && !low_wr |=> count_ff == $past(count_ff))
    else $error("count moved while stopped");

  high_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.eight_bit_select && !low_wr |=> count_ff[15:8] == $past(count_ff[15:8]))
    else $error("high byte moved in 8-bit mode");

  timer_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.timer_run && !ctrl_ff.count_source_select && ctrl_ff.prescaler_bypass
    && !ctrl_ff.eight_bit_select && !i_sleep && inhibit_ff == 2'h0 && !low_wr
    && icyc_tick |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("timer did not step on instruction cycle");

  inhibit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    low_wr ##1 !low_wr [*5] |=> count_ff == $past(count_ff, 5))
    else $error("count moved inside inhibit window");

  presc_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    low_wr && !ctrl_ff.prescaler_bypass |=> presc_ff == 8'h00 && $stable(ctrl_ff))
    else $error("prescaler not cleared by low write");

  presc_ratio_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.prescale_ratio == 3'h0 && presc_out |-> presc_ff[0])
    else $error("prescaler fired off ratio");

  ovf_flag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wrap |=> flag_ff && ($past(ctrl_ff.eight_bit_select) ? count_ff[7:0] == 8'h00
                                                         : count_ff == 16'h0000)
    || $past(low_wr))
    else $error("wrap did not set flag");

  irq_mask_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_overflow_irq |-> irq_en_ff && flag_ff)
    else $error("interrupt leaked while masked");

  sleep_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_sleep && !low_wr |=> count_ff == $past(count_ff))
    else $error("count moved in sleep");

  high_copy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    low_rd |=> high_buf_ff == $past(count_ff[15:8]))
    else $error("low read did not copy high byte");

  high_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    low_wr |=> count_ff == {$past(high_buf_ff), $past(wbyte)})
    else $error("low write did not load 16 bits");

  pin_lat_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pin_edge |-> pin_ff[1] != $past(pin_ff[1]))
    else $error("edge not from synchronised level");

  icyc_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    icyc_tick |=> icyc_ff == 8'h00 && o_instruction_clock)
    else $error("instruction cycle did not restart");

  iclk_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    icyc_ff == 8'(ICYC_DIV / 2 - 1) |=> !o_instruction_clock)
    else $error("instruction clock not low in second half");

  src_timer_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ctrl_ff.count_source_select && src_pulse |=> icyc_ff == 8'h00)
    else $error("timer source off instruction cycle");

  edge_rise_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.count_source_select && !ctrl_ff.edge_polarity_select && src_pulse
    |-> pin_ff[1] && !$past(pin_ff[1]))
    else $error("rising mode counted a non-rising edge");

  edge_fall_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.count_source_select && ctrl_ff.edge_polarity_select && src_pulse
    |-> !pin_ff[1] && $past(pin_ff[1]))
    else $error("falling mode counted a non-falling edge");

  bypass_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.timer_run && ctrl_ff.prescaler_bypass && !ctrl_ff.eight_bit_select
    && src_pulse && !i_sleep && inhibit_ff == 2'h0 && !low_wr
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("bypassed source did not step count");

  presc_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.prescaler_bypass |=> $stable(presc_ff))
    else $error("prescaler moved while bypassed");

  inhibit_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    low_wr |=> inhibit_ff == `INHIBIT_ICYC)
    else $error("inhibit window not armed");

  presc_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    presc_ff == 8'hFF && src_pulse && !ctrl_ff.prescaler_bypass && ctrl_ff.timer_run
    && !i_sleep && !low_wr |=> presc_ff == 8'h00)
    else $error("prescaler not eight bits wide");

  presc_full_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_ff.prescale_ratio == 3'h7 && presc_out |-> presc_ff == 8'hFF)
    else $error("longest ratio fired early");

  flag_only_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(flag_ff) |-> $past(wrap) || $past(wr_en && i_avs.address == `OFF_IRQ_STATUS))
    else $error("flag set without wrap");

  irq_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flag_ff && irq_en_ff |-> o_overflow_irq)
    else $error("enabled interrupt not raised");

  sleep_presc_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_sleep && !low_wr |=> $stable(presc_ff))
    else $error("prescaler moved in sleep");

  high_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en && i_avs.address == `OFF_HIGH_BUF |=> high_buf_ff == $past(wbyte))
    else $error("high buffer write lost");

  high_isolated_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en && i_avs.address == `OFF_HIGH_BUF && !ctrl_ff.timer_run |=> $stable(count_ff))
    else $error("buffer write reached the counter");

  ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en && i_avs.address == `OFF_CONTROL |=> ctrl_ff == $past(wbyte))
    else $error("control write not applied");
endmodule

// file: bench/count_pin_source.sv
// Count pin source: square wave with a 16-clock period while enabled.
// Assumes the bench enables it for whole periods, so the pin rests low.
`timescale 1ns/100ps
module count_pin_source (
  input  wire logic i_clk,
  input  wire logic i_en,
  output logic      o_pin
);
  logic [3:0] phase_ff;
  // Eight clocks per level, well above synchroniser needs
  always_ff @(posedge i_clk) begin
    if (!i_en) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= phase_ff + 4'h1;
    end
  end
  assign o_pin = phase_ff[3];
endmodule

// file: bench/prescaled_timer_counter_8_16_bench.sv
// Directed bench for the timer/counter over its Avalon-MM slave.
// Assumes one wait cycle per access; all waits are bounded by the timeout.
`timescale 1ns/100ps
module prescaled_timer_counter_8_16_bench;
  import timer_pkg::*;
  logic        i_clk, i_rstn, i_sleep, pin_en, ext_pin, wreq, irq, iclk;
  logic [31:0] rdata, v0, v1;
  avs_req_t    req;
  int          miscompares, comparisons, cycles;
  logic [7:0]  mode [5] = '{8'hE8, 8'hF8, 8'hE0, 8'hF1, 8'h68};
  logic [7:0]  expc [5] = '{8'h04, 8'h04, 8'h02, 8'h01, 8'h00};
  logic [31:0] ov [3]   = '{32'h4800FEC8, 32'h0800F088, 32'h08FFF088};
  logic        efl [3]  = '{1'b1, 1'b0, 1'b1};

  prescaled_timer_counter_8_16 dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs(req),
    .o_avs_waitrequest(wreq), .o_avs_readdata(rdata), .i_external_count_input(ext_pin),
    .i_sleep(i_sleep), .o_instruction_clock(iclk), .o_overflow_irq(irq));
  count_pin_source src_u (.i_clk(i_clk), .i_en(pin_en), .o_pin(ext_pin));

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{read: 1'b0, write: 1'b1, address: a, byteenable: 4'hF, writedata: {24'h0, d}};
    do @(posedge i_clk); while (wreq !== 1'b0);
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    req <= '{read: 1'b1, write: 1'b0, address: a, byteenable: 4'hF, writedata: 32'h0};
    do @(posedge i_clk); while (wreq !== 1'b0);
    d = rdata;
    req.read <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Gap r+3 clocks between the two samples; whole instruction cycles only
  task automatic rate(input int r, input logic [7:0] e, input string n);
    rd(4'h0, v0);
    repeat (r) @(posedge i_clk);
    rd(4'h0, v1);
    chk(n, {24'h0, e}, {24'h0, v1[7:0] - v0[7:0]});
  endtask

  task automatic pulses(input int n);
    @(posedge i_clk);
    pin_en <= 1'b1;
    repeat (16 * n) @(posedge i_clk);
    pin_en <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Ceiling well above the roughly 10k cycles the tests need
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    i_rstn = 1'b0;
    i_sleep = 1'b0;
    pin_en = 1'b0;
    req = '0;
    miscompares = 0;
    comparisons = 0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(4'h8, v0);
    chk("control", 32'hFF, v0);
    rd(4'h4, v0);
    chk("high_buffer", 32'h0, v0);
    rd(4'hC, v0);
    chk("status", 32'h0, v0);
    v0 = 32'h0;
    repeat (40) begin
      @(posedge i_clk);
      v0 = v0 + {31'h0, iclk};
    end
    chk("iclk_duty", 32'h14, v0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(4'h8, mode[i]);
      wr(4'h0, 8'h00);
      repeat (12) @(posedge i_clk);
      pulses(4);
      rd(4'h0, v0);
      chk("pin_count", {24'h0, expc[i]}, v0);
    end
    $display("test count pin done");
    wr(4'h8, 8'hC8);
    rate(397, 8'h64, "tick_rate");
    for (int n = 0; n < 8; n++) begin
      wr(4'h8, {5'b11000, n[2:0]});
      wr(4'h0, 8'h00);
      // Inhibited ticks would swallow a prescaler output at 1:2
      repeat (12) @(posedge i_clk);
      rate(1021, 8'h80 >> n, "prescale_rate");
    end
    wr(4'h8, 8'hC8);
    i_sleep <= 1'b1;
    rate(397, 8'h00, "sleep_hold");
    i_sleep <= 1'b0;
    $display("test timer rates done");
    wr(4'h8, 8'h08);
    wr(4'h4, 8'hAB);
    wr(4'h0, 8'hCD);
    wr(4'h4, 8'h00);
    rd(4'h0, v0);
    chk("low16", 32'hCD, v0);
    rd(4'h4, v0);
    chk("high16", 32'hAB, v0);
    $display("test 16-bit access done");
    // Stop, load, clear flag, run, let it wrap or not, stop again
    for (int i = 0; i < 3; i++) begin
      wr(4'h8, ov[i][31:24]);
      wr(4'h4, ov[i][23:16]);
      wr(4'h0, ov[i][15:8]);
      wr(4'hC, 8'h00);
      wr(4'h8, ov[i][7:0]);
      repeat (200) @(posedge i_clk);
      wr(4'h8, 8'h08);
      rd(4'hC, v0);
      chk("overflow_flag", {31'h0, efl[i]}, v0);
      chk("irq_masked", 32'h0, {31'h0, irq});
    end
    wr(4'hC, 8'h03);
    @(posedge i_clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(4'hC, 8'h02);
    @(posedge i_clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    $display("test overflow done");
    finish_test();
  end
endmodule
